// [verilog/rtccs_pkg.sv]
/*
  Constants and carrier types for the control, status and reset logic of
  the real-time clock. Assumes a 125 MHz system clock.
*/
package rtccs_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CS_ONE   = 4'h0;
  localparam logic [3:0] ADDR_CS_TWO   = 4'h1;
  localparam logic [3:0] ADDR_VL_SEC   = 4'h2;
  localparam logic [3:0] ADDR_MIN_ALM  = 4'h9;
  localparam logic [3:0] ADDR_HOUR_ALM = 4'ha;
  localparam logic [3:0] ADDR_DAY_ALM  = 4'hb;
  localparam logic [3:0] ADDR_WDAY_ALM = 4'hc;
  localparam logic [3:0] ADDR_CLOCK_OUTPUT_PIN   = 4'hd;
  localparam logic [3:0] ADDR_TIMER_CT = 4'he;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CS1_TEST_BIT   = 7;
  localparam int CS1_HALT_BIT   = 5;
  localparam int CS1_PERMIT_BIT = 3;
  localparam int CS2_TP_BIT     = 4;
  localparam int CS2_AF_BIT     = 3;
  localparam int CS2_TF_BIT     = 2;
  localparam int CS2_AIE_BIT    = 1;
  localparam int CS2_TIE_BIT    = 0;
  localparam int TOP_BIT        = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic       RST_TEST   = 1'b0;
  localparam logic       RST_HALT   = 1'b0;
  localparam logic       RST_PERMIT = 1'b1;
  localparam logic [4:0] RST_CS2    = 5'h00;
  localparam logic       RST_VL     = 1'b1;
  localparam logic [3:0] RST_AE     = 4'hf;
  localparam logic [1:0] RST_FD     = 2'h0;
  localparam logic       RST_TE     = 1'b0;
  localparam logic [1:0] RST_TD     = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 125;
  localparam int OVR_STEP_MIN_NS  = 1000;
  localparam int OVR_STEP_CYC     = (OVR_STEP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int OVR_CNT_W        = $clog2(OVR_STEP_CYC + 1);
  localparam int IRQ_PULSE_NS     = 15625;
  localparam int IRQ_PULSE_CYC    = (IRQ_PULSE_NS * CLK_MHZ) / 1000;
  localparam int IRQ_CNT_W        = $clog2(IRQ_PULSE_CYC + 1);

  // Override entry pattern, {scl,sda} per step, step 0 in low bits
  localparam logic [7:0] OVR_SEQ  = 8'h4e;
  localparam logic [1:0] OVR_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OVR_WAIT = 2'b00,
    OVR_HOLD = 2'b01,
    OVR_DONE = 2'b10
  } rtccs_ovr_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtccs_req_s;

endpackage

// [verilog/rtccs_top.sv]
/*
  Control/status registers, internal reset and reset-override detector
  of the real-time clock, with interrupt output gating.
  Assumes the serial-bus engine delivers byte accesses as rtccs_req_s on
  mclk; the pins and oscillator status arrive asynchronously.
*/
// Contract
// - Control one bit 7 selects external-drive test mode; zero is normal.
// - Halt bit 5 stops time-keeping and clears the divider chain.
// - While halted, the clock output carries the undivided oscillator.
// - While halted, the serial-bus watchdog is disabled.
// - Control one bit 3 permits reset override; resets to one.
// - Level mode: interrupt asserted while enabled timer or alarm flag set.
// - Alarm and timer enables gate their flags onto the interrupt.
// - Pulse mode: timer events pulse; enabled alarm flag holds output low.
// - Control two bit 3 reads alarm flag; writing zero clears it.
// - Control two bit 2 reads timer flag; writing zero clears it.
// - Internal reset held while the oscillator is stopped.
// - Reset initialises bus logic including the address pointer.
// - No bus transfers are served during reset.
// - Reset loads the documented values into the defined bits.
// - Bits without reset value are untouched by reset.
// - Recognised override leaves reset at once and opens the bus.
// - Writing permit zero cancels an active override.
// - Override entry ignored unless the permit bit is one.
// - Clearing permit otherwise only blocks override entry.
// - Voltage-low flag, set by reset, marks time as untrustworthy.
`timescale 1ns/1ps
module rtccs_top
  import rtccs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       osc_running,
  input  wire logic       vlow_detect,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       alarm_event,
  input  wire logic       timer_event,
  input  wire rtccs_req_s reg_req,
  output logic [7:0]      reg_rdata_r,
  output logic            internal_reset_r,
  output logic            bus_reset_r,
  output logic            bus_enable_r,
  output logic            external_drive_test_mode_r,
  output logic            timekeep_run_r,
  output logic            divider_clear_r,
  output logic            clock_output_pin_undivided_r,
  output logic            watchdog_enable_r,
  output logic            voltage_low_flag_r,
  output logic [3:0]      alarm_disable_r,
  output logic [1:0]      clock_output_pin_freq_select_r,
  output logic            timer_run_r,
  output logic [1:0]      timer_source_select_r,
  output logic            irq_o_r,
  output logic            irq_oe_r
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic       osc_ok;
  logic       vlow_s;
  logic [1:0] pins;

  always_ff @(posedge mclk) begin
    sync1_r <= {osc_running, vlow_detect, scl_in, sda_in};
    sync2_r <= sync1_r;
  end

  assign osc_ok = sync2_r[3];
  assign vlow_s = sync2_r[2];
  assign pins   = sync2_r[1:0];

  // ----------------------------------------------------------------
  // Internal reset
  // ----------------------------------------------------------------
  logic override_r;
  logic rst_any;
  logic wr_ok;
  logic rd_ok;

  // Only the chip reset or permit zero clears the override; the internal reset must not
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      internal_reset_r <= 1'b1;
    end else begin
      internal_reset_r <= !osc_ok && !override_r;
    end
  end

  assign rst_any = !reset_n || internal_reset_r;
  assign wr_ok   = reg_req.wr && !rst_any;
  assign rd_ok   = reg_req.rd && !rst_any;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_reset_r  <= 1'b1;
      bus_enable_r <= 1'b0;
    end else begin
      bus_reset_r  <= !osc_ok && !override_r;
      bus_enable_r <= osc_ok || override_r;
    end
  end

  // ----------------------------------------------------------------
  // Control one
  // ----------------------------------------------------------------
  logic halt_r;
  logic permit_r;

  always_ff @(posedge mclk) begin
    if (rst_any) begin
      external_drive_test_mode_r <= RST_TEST;
      halt_r                     <= RST_HALT;
      permit_r                   <= RST_PERMIT;
    end else if (wr_ok && reg_req.addr == ADDR_CS_ONE) begin
      external_drive_test_mode_r <= reg_req.wdata[CS1_TEST_BIT];
      halt_r                     <= reg_req.wdata[CS1_HALT_BIT];
      permit_r                   <= reg_req.wdata[CS1_PERMIT_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_any) begin
      timekeep_run_r     <= 1'b1;
      divider_clear_r    <= 1'b0;
      clock_output_pin_undivided_r <= 1'b0;
      watchdog_enable_r  <= 1'b1;
    end else begin
      timekeep_run_r     <= !halt_r;
      divider_clear_r    <= halt_r;
      clock_output_pin_undivided_r <= halt_r;
      watchdog_enable_r  <= !halt_r;
    end
  end

  // ----------------------------------------------------------------
  // Control two and flags
  // ----------------------------------------------------------------
  logic tp_r;
  logic af_r;
  logic tf_r;
  logic aie_r;
  logic tie_r;
  logic cs2_wr;

  assign cs2_wr = wr_ok && reg_req.addr == ADDR_CS_TWO;

  always_ff @(posedge mclk) begin
    if (rst_any) begin
      {tp_r, af_r, tf_r, aie_r, tie_r} <= RST_CS2;
    end else begin
      if (cs2_wr) begin
        tp_r  <= reg_req.wdata[CS2_TP_BIT];
        aie_r <= reg_req.wdata[CS2_AIE_BIT];
        tie_r <= reg_req.wdata[CS2_TIE_BIT];
      end
      // Event wins over a clearing write in the same cycle
      if (alarm_event) begin
        af_r <= 1'b1;
      end else if (cs2_wr && !reg_req.wdata[CS2_AF_BIT]) begin
        af_r <= 1'b0;
      end
      if (timer_event) begin
        tf_r <= 1'b1;
      end else if (cs2_wr && !reg_req.wdata[CS2_TF_BIT]) begin
        tf_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Other defined bits (undefined neighbours live elsewhere)
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst_any) begin
      voltage_low_flag_r <= RST_VL;
    end else if (vlow_s) begin
      voltage_low_flag_r <= 1'b1;
    end else if (wr_ok && reg_req.addr == ADDR_VL_SEC) begin
      voltage_low_flag_r <= reg_req.wdata[TOP_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst_any) begin
      alarm_disable_r       <= RST_AE;
      clock_output_pin_freq_select_r  <= RST_FD;
      timer_run_r           <= RST_TE;
      timer_source_select_r <= RST_TD;
    end else if (wr_ok) begin
      case (reg_req.addr)
        ADDR_MIN_ALM:  alarm_disable_r[0] <= reg_req.wdata[TOP_BIT];
        ADDR_HOUR_ALM: alarm_disable_r[1] <= reg_req.wdata[TOP_BIT];
        ADDR_DAY_ALM:  alarm_disable_r[2] <= reg_req.wdata[TOP_BIT];
        ADDR_WDAY_ALM: alarm_disable_r[3] <= reg_req.wdata[TOP_BIT];
        ADDR_CLOCK_OUTPUT_PIN:   clock_output_pin_freq_select_r <= reg_req.wdata[1:0];
        ADDR_TIMER_CT: begin
          timer_run_r           <= reg_req.wdata[TOP_BIT];
          timer_source_select_r <= reg_req.wdata[1:0];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (reg_req.addr)
      ADDR_CS_ONE: begin
        rd_mux[CS1_TEST_BIT]   = external_drive_test_mode_r;
        rd_mux[CS1_HALT_BIT]   = halt_r;
        rd_mux[CS1_PERMIT_BIT] = permit_r;
      end
      ADDR_CS_TWO:   rd_mux = {3'h0, tp_r, af_r, tf_r, aie_r, tie_r};
      ADDR_VL_SEC:   rd_mux = {voltage_low_flag_r, 7'h00};
      ADDR_MIN_ALM:  rd_mux = {alarm_disable_r[0], 7'h00};
      ADDR_HOUR_ALM: rd_mux = {alarm_disable_r[1], 7'h00};
      ADDR_DAY_ALM:  rd_mux = {alarm_disable_r[2], 7'h00};
      ADDR_WDAY_ALM: rd_mux = {alarm_disable_r[3], 7'h00};
      ADDR_CLOCK_OUTPUT_PIN:   rd_mux = {6'h00, clock_output_pin_freq_select_r};
      ADDR_TIMER_CT: rd_mux = {timer_run_r, 5'h00, timer_source_select_r};
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst_any) begin
      reg_rdata_r <= 8'h00;
    end else if (rd_ok) begin
      reg_rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  logic [IRQ_CNT_W-1:0] pulse_cnt_r;
  logic                 irq_level;

  always_ff @(posedge mclk) begin
    if (rst_any) begin
      pulse_cnt_r <= '0;
    end else if (timer_event && tie_r && tp_r) begin
      pulse_cnt_r <= IRQ_CNT_W'(IRQ_PULSE_CYC);
    end else if (pulse_cnt_r != '0) begin
      pulse_cnt_r <= pulse_cnt_r - 1'b1;
    end
  end

  assign irq_level = (af_r && aie_r) ||
                     (tp_r ? (pulse_cnt_r != '0 && tie_r)
                           : (tf_r && tie_r));

  // Open drain: drive low only while asserted
  always_ff @(posedge mclk) begin
    if (rst_any) begin
      irq_o_r  <= 1'b1;
      irq_oe_r <= 1'b0;
    end else begin
      irq_o_r  <= !irq_level;
      irq_oe_r <= irq_level;
    end
  end

  // ----------------------------------------------------------------
  // Reset override detector
  // ----------------------------------------------------------------
  rtccs_ovr_e           ovr_st_r;
  logic [1:0]           step_r;
  logic [OVR_CNT_W-1:0] step_cnt_r;
  logic                 step_met;
  logic [1:0]           want;
  logic [1:0]           want_next;

  assign want      = OVR_SEQ[{step_r, 1'b0} +: 2];
  assign want_next = OVR_SEQ[{step_r + 2'h1, 1'b0} +: 2];
  assign step_met  = step_cnt_r >= OVR_CNT_W'(OVR_STEP_CYC);

  // Chip reset, permit zero or active override only; the detector must run while the oscillator is off
  always_ff @(posedge mclk) begin
    if (!reset_n || !permit_r || override_r) begin
      ovr_st_r   <= OVR_WAIT;
      step_r     <= 2'h0;
      step_cnt_r <= '0;
    end else begin
      case (ovr_st_r)
        OVR_WAIT: begin
          step_r     <= 2'h0;
          step_cnt_r <= '0;
          if (pins == OVR_SEQ[1:0]) begin
            ovr_st_r <= OVR_HOLD;
          end
        end
        OVR_HOLD: begin
          if (pins == want) begin
            if (!step_met) begin
              step_cnt_r <= step_cnt_r + 1'b1;
            end else if (step_r == OVR_LAST) begin
              ovr_st_r <= OVR_DONE;
            end
          end else if (step_met && step_r != OVR_LAST &&
                       pins == want_next) begin
            step_r     <= step_r + 2'h1;
            step_cnt_r <= '0;
          end else begin
            ovr_st_r <= OVR_WAIT;
          end
        end
        OVR_DONE: ovr_st_r <= OVR_WAIT;
        default:  ovr_st_r <= OVR_WAIT;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      override_r <= 1'b0;
    end else if (ovr_st_r == OVR_DONE) begin
      override_r <= 1'b1;
    end else if (!permit_r) begin
      override_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_halt_clears_div: assert property (@(posedge mclk) disable iff (rst_any)
    halt_r |=> divider_clear_r && !timekeep_run_r && clock_output_pin_undivided_r)
    else $error("halt not reflected");
  a_halt_no_wdog: assert property (@(posedge mclk) disable iff (rst_any)
    $rose(halt_r) |=> !watchdog_enable_r)
    else $error("watchdog alive in halt");
  a_level_irq: assert property (@(posedge mclk) disable iff (rst_any)
    (!tp_r && tf_r && tie_r) |=> irq_oe_r && !irq_o_r)
    else $error("level irq missing");
  a_gate_irq: assert property (@(posedge mclk) disable iff (rst_any)
    (!aie_r && !tie_r) |=> !irq_oe_r)
    else $error("irq without enable");
  a_alarm_hold: assert property (@(posedge mclk) disable iff (rst_any)
    (tp_r && af_r && aie_r)[*2] |=> irq_oe_r)
    else $error("alarm not held in pulse mode");
  a_af_clear: assert property (@(posedge mclk) disable iff (rst_any)
    (cs2_wr && !reg_req.wdata[CS2_AF_BIT] && !alarm_event) |=> !af_r)
    else $error("alarm flag not cleared");
  a_tf_keep: assert property (@(posedge mclk) disable iff (rst_any)
    (tf_r && cs2_wr && reg_req.wdata[CS2_TF_BIT]) |=> tf_r)
    else $error("timer flag lost");
  a_osc_reset: assert property (@(posedge mclk) disable iff (!reset_n)
    (!osc_ok && !override_r) |=> internal_reset_r && !bus_enable_r)
    else $error("reset not held");
  a_permit_cancel: assert property (@(posedge mclk) disable iff (!reset_n)
    (override_r && !permit_r && ovr_st_r != OVR_DONE) |=> !override_r)
    else $error("override not cancelled");
  a_reset_values: assert property (@(posedge mclk)
    !reset_n |=> permit_r && !halt_r && voltage_low_flag_r &&
                 timer_source_select_r == RST_TD)
    else $error("bad reset values");

endmodule

// [dv/rtccs_host_model.sv]
/*
  Host-side model: issues byte accesses and toggles the bus pins.
  Assumes the register port of rtccs_top and falling-edge driving.
*/
`timescale 1ns/1ps
module rtccs_host_model
  import rtccs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rdata,
  output rtccs_req_s      req,
  output logic            scl,
  output logic            sda
);
  // ----------------------------------------------------------------
  // Idle: pins float to their pull-ups
  // ----------------------------------------------------------------
  initial begin
    req = '0;
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = (a == ADDR_CS_ONE) ? 8'ha8 : (a == ADDR_CS_TWO) ? 8'h1f : 8'hff;
    @(negedge mclk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d & m};
    @(negedge mclk);
    req = '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    req = '0;
    d = rdata;
  endtask

  // Each step held past its minimum, sync delay included
  task automatic ovr_seq();
    for (int i = 0; i < 4; i++) begin
      {scl, sda} = OVR_SEQ[2*i +: 2];
      repeat (OVR_STEP_CYC + 10) @(negedge mclk);
    end
    {scl, sda} = 2'h3;
  endtask
endmodule

// [dv/tb_top.sv]
/*
  Self-checking bench for the control, status and reset block.
  Assumes rtccs_host_model as the far side of the register port.
*/
`timescale 1ns/1ps
module tb_top
  import rtccs_pkg::*;
;
  logic        mclk, reset_n, osc_running, vlow_detect, scl_in, sda_in;
  logic        alarm_event, timer_event, irst, brst, ben, tmode, run;
  logic        dclr, cund, wden, vl, tr, irq, irq_oe;
  rtccs_req_s  req;
  logic [7:0]  rdata, rv;
  logic [3:0]  aed;
  logic [1:0]  fd, td;
  logic [31:0] seed;
  int          n_errors, n_checks;

  rtccs_top rtccs_top_inst (
    .mclk(mclk), .reset_n(reset_n), .osc_running(osc_running),
    .vlow_detect(vlow_detect), .scl_in(scl_in), .sda_in(sda_in),
    .alarm_event(alarm_event), .timer_event(timer_event),
    .reg_req(req), .reg_rdata_r(rdata), .internal_reset_r(irst),
    .bus_reset_r(brst), .bus_enable_r(ben),
    .external_drive_test_mode_r(tmode), .timekeep_run_r(run),
    .divider_clear_r(dclr), .clock_output_pin_undivided_r(cund),
    .watchdog_enable_r(wden), .voltage_low_flag_r(vl),
    .alarm_disable_r(aed), .clock_output_pin_freq_select_r(fd),
    .timer_run_r(tr), .timer_source_select_r(td),
    .irq_o_r(irq), .irq_oe_r(irq_oe)
  );

  rtccs_host_model rtccs_host_model_inst (
    .mclk(mclk), .rdata(rdata), .req(req), .scl(scl_in), .sda(sda_in)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Halt drives four outputs at once; test bit rides alongside
  function automatic logic [7:0] ctl_view(input logic [7:0] d);
    return {d[7], ~d[5], d[5], d[5], ~d[5], 3'h0};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rtccs_host_model_inst.rd(a, rv);
    chk(rv, e);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    rtccs_host_model_inst.wr(a, d);
  endtask

  task automatic ev(input logic alarm);
    @(negedge mclk);
    if (alarm) alarm_event = 1'b1;
    else timer_event = 1'b1;
    @(negedge mclk);
    alarm_event = 1'b0;
    timer_event = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Whole run is about 5400 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    osc_running = 1'b1;
    vlow_detect = 1'b0;
    alarm_event = 1'b0;
    timer_event = 1'b0;
    n_errors = 0;
    n_checks = 0;
    seed = 32'h39;
    tick(3);
    reset_n = 1'b1;
    tick(2);
    chk({aed, fd, td}, 8'hf3);
    chk({7'h0, tr}, 8'h00);
    chk({irst, ben, 6'h0}, 8'h40);
    chk({7'h0, vl}, 8'h01);
    rchk(ADDR_CS_ONE, 8'h08);
    rchk(ADDR_CS_TWO, 8'h00);
    rchk(ADDR_VL_SEC, 8'h80);
    wr(4'h3, 8'hff);
    rchk(4'h3, 8'h00);
    wr(ADDR_VL_SEC, 8'h00);
    rchk(ADDR_VL_SEC, 8'h00);
    chk({7'h0, vl}, 8'h00);
    vlow_detect = 1'b1;
    tick(4);
    vlow_detect = 1'b0;
    rchk(ADDR_VL_SEC, 8'h80);
    chk({7'h0, vl}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(ADDR_CS_ONE, seed[7:0]);
      tick(2);
      chk({tmode, run, dclr, cund, wden, 3'h0}, ctl_view(seed[7:0]));
      rchk(ADDR_CS_ONE, seed[7:0] & 8'ha8);
      wr(ADDR_CS_TWO, seed[15:8]);
      rchk(ADDR_CS_TWO, seed[15:8] & 8'h13);
    end
    wr(ADDR_CS_ONE, 8'h08);
    // Level mode, timer enabled only
    wr(ADDR_CS_TWO, 8'h01);
    ev(1'b0);
    tick(3);
    chk({6'h0, irq_oe, irq}, 8'h02);
    wr(ADDR_CS_TWO, 8'h05);
    ev(1'b1);
    rchk(ADDR_CS_TWO, 8'h0d);
    wr(ADDR_CS_TWO, 8'h09);
    tick(3);
    chk({7'h0, irq_oe}, 8'h00);
    wr(ADDR_CS_TWO, 8'h0b);
    tick(3);
    chk({7'h0, irq_oe}, 8'h01);
    wr(ADDR_CS_TWO, 8'h03);
    tick(3);
    chk({7'h0, irq_oe}, 8'h00);
    // Pulse mode: width is the package constant
    wr(ADDR_CS_TWO, 8'h11);
    ev(1'b0);
    tick(3);
    chk({7'h0, irq_oe}, 8'h01);
    tick(1000);
    chk({7'h0, irq_oe}, 8'h01);
    tick(IRQ_PULSE_CYC - 993);
    chk({7'h0, irq_oe}, 8'h00);
    // Dropping the timer enable must cut a running pulse
    ev(1'b0);
    tick(3);
    wr(ADDR_CS_TWO, 8'h10);
    tick(2);
    chk({7'h0, irq_oe}, 8'h00);
    wr(ADDR_CS_TWO, 8'h13);
    ev(1'b1);
    tick(2100);
    chk({7'h0, irq_oe}, 8'h01);
    wr(ADDR_CS_TWO, 8'h13);
    // Move alarm disable bit 0, clock output and timer control bits away from their reset values
    wr(ADDR_MIN_ALM, 8'h00);
    wr(ADDR_CLOCK_OUTPUT_PIN, 8'h01);
    wr(ADDR_TIMER_CT, 8'h80);
    tick(1);
    chk({aed, fd, td}, 8'he4);
    chk({7'h0, tr}, 8'h01);
    osc_running = 1'b0;
    tick(6);
    chk({irst, brst, ben, irq_oe, 4'h0}, 8'hc0);
    chk({aed, fd, td}, 8'hf3);
    chk({7'h0, tr}, 8'h00);
    wr(ADDR_CS_TWO, 8'h03);
    osc_running = 1'b1;
    tick(6);
    rchk(ADDR_CS_TWO, 8'h00);
    // Override entry while the oscillator is stopped
    osc_running = 1'b0;
    tick(6);
    rtccs_host_model_inst.ovr_seq();
    repeat (20) if (irst) @(negedge mclk);
    chk({irst, ben, 6'h0}, 8'h40);
    wr(ADDR_CS_ONE, 8'h88);
    tick(2);
    chk({7'h0, tmode}, 8'h01);
    wr(ADDR_CS_ONE, 8'h80);
    tick(4);
    chk({irst, tmode, 6'h0}, 8'h80);
    osc_running = 1'b1;
    tick(6);
    // Permit clear: sequence ignored, nothing else disturbed
    wr(ADDR_CS_TWO, 8'h03);
    wr(ADDR_CS_ONE, 8'h00);
    // Permit returns during the last step; a detector that kept
    // tracking while forbidden would complete and latch the override
    fork
      rtccs_host_model_inst.ovr_seq();
      begin
        tick(3 * (OVR_STEP_CYC + 10) + 20);
        wr(ADDR_CS_ONE, 8'h08);
      end
    join
    rchk(ADDR_CS_TWO, 8'h03);
    osc_running = 1'b0;
    tick(6);
    chk({7'h0, irst}, 8'h01);
    osc_running = 1'b1;
    tick(6);
    tally_and_finish();
  end
endmodule
